// ---- hw/acf_pkg.sv ----
/*
  constants for the accelerometer configuration bank: register offsets, field
  layout, reset values, trigger modes and timing counts.
  assumes a 10 MHz system clock that also serves as the oscillator.
*/
package acf_pkg;

  // timing
  localparam int SYS_CLK_HZ      = 10_000_000;
  localparam int ODR_MAX_HZ      = 4000;
  localparam int ODR_BASE_CYC    = SYS_CLK_HZ / ODR_MAX_HZ;
  localparam int INTERP_MIN_CYC  = 14;
  localparam int INTERP_MAX_CYC  = 8204;
  localparam int INTERP_STEP_CYC = 8;

  // register offsets
  localparam logic [7:0] ADDR_FILTER = 8'h28;
  localparam logic [7:0] ADDR_WMARK  = 8'h29;
  localparam logic [7:0] ADDR_ROUTE  = 8'h2a;
  localparam logic [7:0] ADDR_TSYNC  = 8'h2b;

  // reset values and writable-bit masks
  localparam logic [7:0] RST_FILTER  = 8'h00;
  localparam logic [7:0] RST_WMARK   = 8'h60;
  localparam logic [7:0] RST_ROUTE   = 8'h00;
  localparam logic [7:0] RST_TSYNC   = 8'h00;
  localparam logic [7:0] MASK_FILTER = 8'h7f;
  localparam logic [7:0] MASK_WMARK  = 8'h7f;
  localparam logic [7:0] MASK_ROUTE  = 8'hff;
  localparam logic [7:0] MASK_TSYNC  = 8'h07;

  // field layout
  localparam int HPC_LSB      = 4;
  localparam int HPC_W        = 3;
  localparam int RATE_W       = 4;
  localparam int WMARK_W      = 7;
  localparam int ROUTE_B_LSB  = 4;
  localparam int EXTCLK_BIT   = 2;
  localparam int EV_N         = 4;
  localparam logic [RATE_W-1:0] RATE_CODE_MAX = 4'ha;

  // event slots inside each routing nibble
  localparam int EV_READY = 0;
  localparam int EV_FULL  = 1;
  localparam int EV_OVR   = 2;
  localparam int EV_ACT   = 3;

  // high-pass shift = base + step * code
  localparam int HPF_SHIFT_BASE = 4;
  localparam int HPF_SHIFT_STEP = 2;
  localparam int HPF_FRAC       = 16;

  typedef enum logic [1:0] {
    TRIG_INTERNAL = 2'b00,
    TRIG_DIRECT   = 2'b01,
    TRIG_INTERP   = 2'b10,
    TRIG_RSVD     = 2'b11
  } acf_trig_mode_e;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_WAIT = 1'b1
  } acf_interp_st_e;

endpackage

// ---- hw/acf_core_if.sv ----
/*
  carrier between the configuration core, the link synchroniser and the
  high-pass stage. pulses are one system clock wide.
*/
`timescale 1ns/1ns
interface acf_core_if #(parameter int W = 20);
  logic                 tick_pulse;
  logic                 trig_pulse;
  logic                 smp_strobe;
  logic [2:0]           corner;
  logic signed [W-1:0]  din;
  logic signed [W-1:0]  dout;

  modport sync_src (output tick_pulse, output trig_pulse);
  modport hpf      (input smp_strobe, input corner, input din, output dout);
  modport core     (input tick_pulse, input trig_pulse, output smp_strobe,
                    output corner, output din, input dout);
endinterface // acf_core_if

// ---- hw/acf_link_sync.sv ----
/*
  link-clock side: samples the trigger pin, divides the external timebase,
  and hands both over to the system clock as toggles.
  assumes the link clock runs while external timing is in use.
*/
`timescale 1ns/1ns
module acf_link_sync #(
  parameter int LINK_DIV = 4
) (
  // system domain
  input  wire logic   sys_clk_i,
  input  wire logic   rst_i,
  // link domain
  input  wire logic   link_clk_i,
  input  wire logic   trig_pin_i,
  // to core
  acf_core_if.sync_src bus
);
  import acf_pkg::*;

  if (LINK_DIV < 1 || LINK_DIV > (1 << 16)) begin : g_bad_div
    $error("acf_link_sync: LINK_DIV must be 1 to 65536");
  end

  logic [1:0]  lrst_q;
  logic [2:0]  trig_q;
  logic        trig_tgl_q;
  logic        tick_tgl_q;
  logic [15:0] div_q;
  logic [2:0]  st_q;
  logic [2:0]  sk_q;

  ////////////////////////////////////////////////////////////////////////
  // link domain
  always_ff @(posedge link_clk_i) begin
    lrst_q <= {lrst_q[0], rst_i};
  end

  always_ff @(posedge link_clk_i) begin
    if (lrst_q[1]) begin
      trig_q     <= 3'h0;
      trig_tgl_q <= 1'b0;
    end else begin
      trig_q <= {trig_q[1:0], trig_pin_i};
      if (trig_q[1] && !trig_q[2]) begin
        trig_tgl_q <= ~trig_tgl_q;
      end
    end
  end

  always_ff @(posedge link_clk_i) begin
    if (lrst_q[1]) begin
      div_q      <= 16'h0;
      tick_tgl_q <= 1'b0;
    end else if (div_q == 16'(LINK_DIV - 1)) begin
      div_q      <= 16'h0;
      tick_tgl_q <= ~tick_tgl_q;
    end else begin
      div_q <= div_q + 16'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // system domain
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      st_q <= 3'h0;
      sk_q <= 3'h0;
    end else begin
      st_q <= {st_q[1:0], trig_tgl_q};
      sk_q <= {sk_q[1:0], tick_tgl_q};
    end
  end

  assign bus.trig_pulse = st_q[1] ^ st_q[2];
  assign bus.tick_pulse = sk_q[1] ^ sk_q[2];

endmodule // acf_link_sync

// ---- hw/acf_highpass.sv ----
/*
  first-order high-pass stage: y = x - lp, lp follows x by a power-of-two step.
  corner code zero passes data straight through. assumes one strobe per sample.
*/
`timescale 1ns/1ns
module acf_highpass #(
  parameter int W = 20
) (
  input  wire logic sys_clk_i,
  input  wire logic rst_i,
  acf_core_if.hpf   bus
);
  import acf_pkg::*;

  localparam int AW = W + HPF_FRAC + 1;

  logic signed [AW-1:0] lp_q;
  logic signed [AW-1:0] x_ext;
  logic signed [AW-1:0] diff;
  logic [4:0]           shift;

  assign x_ext = AW'(bus.din) <<< HPF_FRAC;
  assign diff  = x_ext - lp_q;
  assign shift = 5'(HPF_SHIFT_BASE + HPF_SHIFT_STEP * int'(bus.corner)); // see [RQ2]

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      lp_q <= '0;
    end else if (bus.smp_strobe) begin
      lp_q <= lp_q + (diff >>> shift);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      bus.dout <= '0;
    end else if (bus.smp_strobe) begin
      if (bus.corner == 3'h0) begin
        bus.dout <= bus.din; // see [RQ1]
      end else begin
        bus.dout <= W'(diff >>> HPF_FRAC); // see [RQ2]
      end
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  chk_hpf_bypass: assert property ( // see [RQ1]
    bus.smp_strobe && bus.corner == 3'h0 |=> bus.dout == $past(bus.din))
    else $error("bypassed filter altered data");
  chk_hpf_active: assert property ( // see [RQ2]
    bus.smp_strobe && bus.corner != 3'h0 |=> bus.dout == W'($past(diff) >>> HPF_FRAC))
    else $error("high-pass output not input minus low-pass");

endmodule // acf_highpass

// ---- hw/acf_config_top.sv ----
/*
  configuration bank of a 3-axis accelerometer: filter, watermark, interrupt
  routing and timing source registers, with the sample timing they steer.
  assumes ADC data, buffer count and event levels come from logic on SYS_CLK_I;
  the trigger pin and external timebase belong to LINK_CLK_I.
*/
// Function
// [RQ1] high-pass corner code zero bypasses the high-pass filter
// [RQ2] codes one to six select a first-order high-pass, corner a fraction of rate
// [RQ3] rate code zero means 4000 Hz with 1000 Hz corner, each code halves
// [RQ4] rate code ten gives 3.906 Hz rate and 0.977 Hz low-pass corner
// [RQ5] watermark field sets sample count raising buffer full, 1 to 96
// [RQ6] watermark resets to 0x60 so buffer-full stays quiet by default
// [RQ7] each routing bit lets its event drive its pin; sources combine
// [RQ8] routing bits 7..4 send activity, overrun, full, ready to pin b
// [RQ9] routing bits 3..0 send activity, overrun, full, ready to pin a
// [RQ10] timing bit 2 takes sample timing from the external clock
// [RQ11] trigger mode 00 keeps timing internal, trigger unused
// [RQ12] trigger mode 01 samples on each trigger, ready raised at trigger
// [RQ13] trigger mode 10 signals ready 14 to 8204 cycles after trigger
// [RQ14] interpolated data is the value from one group delay earlier
// [RQ15] polarity bit makes both pins active low when clear, high when set
// [RQ16] host changes these registers only in standby, except high-pass corner
// [RQ17] host writes no reserved codes; reserved bits read zero
// [RQ18] buffer full asserts at count reaching watermark, clears below it
`timescale 1ns/1ns
module acf_config_top #(
  parameter int ADC_W         = 20,
  parameter int ODR_BASE      = acf_pkg::ODR_BASE_CYC,
  parameter int INTERP_MAX    = acf_pkg::INTERP_MAX_CYC,
  parameter int LINK_DIV      = 4
) (
  // clocks and reset
  input  wire logic                    SYS_CLK_I,
  input  wire logic                    RST_I,
  input  wire logic                    LINK_CLK_I,
  // external trigger pin (link domain)
  input  wire logic                    SYNC_TRIG_I,
  // register port
  input  wire logic [7:0]              REG_ADDR_I,
  input  wire logic                    REG_WR_I,
  input  wire logic [7:0]              REG_WDATA_I,
  input  wire logic                    REG_RD_I,
  output logic      [7:0]              REG_RDATA_O,
  // sample path
  input  wire logic signed [ADC_W-1:0] ADC_DATA_I,
  input  wire logic                    SAMPLE_TAKEN_I,
  output logic signed [ADC_W-1:0]      SAMPLE_DATA_O,
  output logic                         DATA_READY_O,
  // buffer and event sources
  input  wire logic [acf_pkg::WMARK_W-1:0] BUF_COUNT_I,
  input  wire logic                    BUF_OVERRUN_I,
  input  wire logic                    ACTIVITY_I,
  input  wire logic                    IRQ_POLARITY_I,
  output logic                         BUF_FULL_O,
  // interrupt pins
  output logic                         IRQ_A_O,
  output logic                         IRQ_B_O
);
  import acf_pkg::*;

  if (ADC_W < 8 || ODR_BASE < 1 || INTERP_MAX < INTERP_MIN_CYC || INTERP_MAX >= (1 << 14)) begin : g_bad
    $error("acf_config_top: unsupported parameter values");
  end

  ////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [31:0] period_of(input logic [RATE_W-1:0] code);
    period_of = 32'(ODR_BASE) << code;
  endfunction

  function automatic logic [13:0] interp_delay(input logic [RATE_W-1:0] code);
    int span;
    span = INTERP_MIN_CYC + INTERP_STEP_CYC * ((1 << code) - 1);
    // a shortened ceiling caps the slower codes too
    if (code >= RATE_CODE_MAX || span > INTERP_MAX) begin
      interp_delay = 14'(INTERP_MAX);
    end else begin
      interp_delay = 14'(span);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] filter_settings_q;
  logic [7:0] buffer_watermark_q;
  logic [7:0] interrupt_routing_q;
  logic [7:0] timing_source_control_q;

  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      filter_settings_q       <= RST_FILTER;
      buffer_watermark_q      <= RST_WMARK; // see [RQ6]
      interrupt_routing_q     <= RST_ROUTE;
      timing_source_control_q <= RST_TSYNC;
    end else if (REG_WR_I) begin
      // reserved bits are dropped on write so they read back zero
      if (REG_ADDR_I == ADDR_FILTER) begin
        filter_settings_q <= REG_WDATA_I & MASK_FILTER;
      end else if (REG_ADDR_I == ADDR_WMARK) begin
        buffer_watermark_q <= REG_WDATA_I & MASK_WMARK; // see [RQ5]
      end else if (REG_ADDR_I == ADDR_ROUTE) begin
        interrupt_routing_q <= REG_WDATA_I & MASK_ROUTE;
      end else if (REG_ADDR_I == ADDR_TSYNC) begin
        timing_source_control_q <= REG_WDATA_I & MASK_TSYNC;
      end
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      REG_RDATA_O <= 8'h00;
    end else if (REG_RD_I) begin
      if (REG_ADDR_I == ADDR_FILTER) begin
        REG_RDATA_O <= filter_settings_q;
      end else if (REG_ADDR_I == ADDR_WMARK) begin
        REG_RDATA_O <= buffer_watermark_q;
      end else if (REG_ADDR_I == ADDR_ROUTE) begin
        REG_RDATA_O <= interrupt_routing_q;
      end else if (REG_ADDR_I == ADDR_TSYNC) begin
        REG_RDATA_O <= timing_source_control_q;
      end else begin
        REG_RDATA_O <= 8'h00;
      end
    end
  end

  // fields
  logic [HPC_W-1:0]   highpass_corner_sel;
  logic [RATE_W-1:0]  rate_lowpass_sel;
  logic [WMARK_W-1:0] wmark;
  logic               external_timebase_en;
  acf_trig_mode_e     trigger_mode_sel;

  assign highpass_corner_sel  = filter_settings_q[HPC_LSB +: HPC_W];
  assign rate_lowpass_sel     = filter_settings_q[RATE_W-1:0];
  assign wmark                = buffer_watermark_q[WMARK_W-1:0];
  assign external_timebase_en = timing_source_control_q[EXTCLK_BIT];
  assign trigger_mode_sel     = acf_trig_mode_e'(timing_source_control_q[1:0]);

  ////////////////////////////////////////////////////////////////////////
  // submodules
  acf_core_if #(.W(ADC_W)) core ();

  acf_link_sync #(.LINK_DIV(LINK_DIV)) u_link (
    .sys_clk_i  (SYS_CLK_I),
    .rst_i      (RST_I),
    .link_clk_i (LINK_CLK_I),
    .trig_pin_i (SYNC_TRIG_I),
    .bus        (core.sync_src)
  );

  acf_highpass #(.W(ADC_W)) u_hpf (
    .sys_clk_i (SYS_CLK_I),
    .rst_i     (RST_I),
    .bus       (core.hpf)
  );

  ////////////////////////////////////////////////////////////////////////
  // sample timing
  logic [31:0]    rate_cnt_q;
  logic [31:0]    output_sample_rate;
  logic           time_step;
  logic           rate_evt;
  logic           present_q;
  logic [13:0]    wait_cnt_q;
  acf_interp_st_e ist_q;
  logic           smp_strobe;
  logic           interp_done;

  // one output period in oscillator cycles
  assign output_sample_rate = period_of(rate_lowpass_sel); // see [RQ3] [RQ4]
  assign time_step = external_timebase_en ? core.tick_pulse : 1'b1; // see [RQ10]
  assign rate_evt  = time_step && (rate_cnt_q >= output_sample_rate - 32'h1);

  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      rate_cnt_q <= 32'h0;
    end else if (rate_evt) begin
      rate_cnt_q <= 32'h0;
    end else if (time_step) begin
      rate_cnt_q <= rate_cnt_q + 32'h1;
    end
  end

  always_comb begin
    case (trigger_mode_sel)
      TRIG_INTERNAL: smp_strobe = rate_evt; // see [RQ11]
      TRIG_DIRECT:   smp_strobe = core.trig_pulse; // see [RQ12]
      TRIG_INTERP:   smp_strobe = core.trig_pulse && ist_q == ST_IDLE; // see [RQ13]
      default:       smp_strobe = 1'b0;
    endcase
  end

  assign core.smp_strobe = smp_strobe;
  assign core.corner     = highpass_corner_sel;
  assign core.din        = ADC_DATA_I;
  assign interp_done     = ist_q == ST_WAIT && wait_cnt_q == 14'h0;

  // interpolation wait: the filtered value from the trigger is held back
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      ist_q      <= ST_IDLE;
      wait_cnt_q <= 14'h0;
    end else begin
      case (ist_q)
        ST_IDLE: begin
          if (trigger_mode_sel == TRIG_INTERP && smp_strobe) begin
            ist_q      <= ST_WAIT;
            wait_cnt_q <= interp_delay(rate_lowpass_sel) - 14'h2; // see [RQ13]
          end
        end
        ST_WAIT: begin
          if (wait_cnt_q == 14'h0) begin
            ist_q <= ST_IDLE;
          end else begin
            wait_cnt_q <= wait_cnt_q - 14'h1;
          end
        end
        default: ist_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      present_q <= 1'b0;
    end else begin
      present_q <= smp_strobe && trigger_mode_sel != TRIG_INTERP;
    end
  end

  // data out and ready; a new sample beats a host acknowledge
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      SAMPLE_DATA_O <= '0;
      DATA_READY_O  <= 1'b0;
    end else if (present_q || interp_done) begin
      SAMPLE_DATA_O <= core.dout; // see [RQ14]
      DATA_READY_O  <= 1'b1;
    end else if (SAMPLE_TAKEN_I) begin
      DATA_READY_O <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // watermark and interrupt pins
  logic [EV_N-1:0] events;
  logic            pin_a_act;
  logic            pin_b_act;

  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      BUF_FULL_O <= 1'b0;
    end else begin
      BUF_FULL_O <= BUF_COUNT_I >= wmark; // see [RQ5] [RQ18]
    end
  end

  assign events[EV_READY] = DATA_READY_O;
  assign events[EV_FULL]  = BUF_FULL_O;
  assign events[EV_OVR]   = BUF_OVERRUN_I;
  assign events[EV_ACT]   = ACTIVITY_I;
  assign pin_a_act = |(events & interrupt_routing_q[EV_N-1:0]); // see [RQ7] [RQ9]
  assign pin_b_act = |(events & interrupt_routing_q[ROUTE_B_LSB +: EV_N]); // see [RQ7] [RQ8]
  assign IRQ_A_O   = IRQ_POLARITY_I ? pin_a_act : ~pin_a_act; // see [RQ15]
  assign IRQ_B_O   = IRQ_POLARITY_I ? pin_b_act : ~pin_b_act; // see [RQ15]

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (RST_I);

  chk_rate_period: assert property ( // see [RQ3]
    rate_lowpass_sel == 4'h0 |-> output_sample_rate == 32'(ODR_BASE))
    else $error("rate code zero not at base period");
  chk_slowest_rate: assert property ( // see [RQ4]
    rate_lowpass_sel == RATE_CODE_MAX |-> output_sample_rate == 32'(ODR_BASE) * 32'd1024)
    else $error("rate code ten period wrong");
  chk_wmark_reset: assert property ( // see [RQ6]
    $past(RST_I) |-> buffer_watermark_q == 8'h60)
    else $error("watermark reset value wrong");
  chk_buf_full: assert property ( // see [RQ5] [RQ18]
    ##1 BUF_FULL_O == ($past(BUF_COUNT_I) >= $past(wmark)))
    else $error("buffer full does not follow watermark");
  chk_pin_b_route: assert property ( // see [RQ8]
    IRQ_POLARITY_I && interrupt_routing_q[7] && ACTIVITY_I |-> IRQ_B_O)
    else $error("activity not routed to pin b");
  chk_pin_a_route: assert property ( // see [RQ7] [RQ9]
    IRQ_POLARITY_I && (events & interrupt_routing_q[3:0]) == 4'h0 |-> !IRQ_A_O)
    else $error("pin a raised without routed event");
  chk_pin_polarity: assert property ( // see [RQ15]
    !IRQ_POLARITY_I && interrupt_routing_q == 8'h00 |-> IRQ_A_O && IRQ_B_O)
    else $error("idle active-low pins not high");
  chk_direct_ready: assert property ( // see [RQ12]
    trigger_mode_sel == TRIG_DIRECT && core.trig_pulse |-> ##2 DATA_READY_O)
    else $error("trigger did not raise ready");
  chk_internal_only: assert property ( // see [RQ11]
    trigger_mode_sel == TRIG_INTERNAL && $rose(DATA_READY_O) |-> $past(rate_evt, 2))
    else $error("ready without internal rate event");
  chk_interp_min: assert property ( // see [RQ13]
    trigger_mode_sel == TRIG_INTERP && smp_strobe |-> ##1 !interp_done [*8] ##1 !interp_done [*4])
    else $error("interpolated ready too early");
  chk_interp_bound: assert property ( // see [RQ13] [RQ14]
    ist_q == ST_WAIT |-> wait_cnt_q <= 14'(INTERP_MAX))
    else $error("interpolation wait beyond bound");
  chk_ext_timebase: assert property ( // see [RQ10]
    external_timebase_en && !core.tick_pulse |-> !rate_evt)
    else $error("rate advanced without external tick");

  cov_internal: cover property (trigger_mode_sel == TRIG_INTERNAL && $rose(DATA_READY_O));
  cov_direct:   cover property (trigger_mode_sel == TRIG_DIRECT && core.trig_pulse);
  cov_interp:   cover property (interp_done);
  cov_full:     cover property ($rose(BUF_FULL_O));

endmodule // acf_config_top

// ---- testbench/acf_host_model.sv ----
/*
  host model: drives the register strobe port, sample acknowledge and the
  external trigger pin. assumes read data is valid one cycle after a read.
*/
`timescale 1ns/1ns
module acf_host_model (
  // clocks
  input  wire logic       clk_i,
  input  wire logic       link_clk_i,
  // register port
  input  wire logic [7:0] rdata_i,
  output logic      [7:0] addr_o,
  output logic            wr_o,
  output logic      [7:0] wdata_o,
  output logic            rd_o,
  // sample acknowledge and trigger
  output logic            taken_o,
  output logic            trig_o
);
  initial begin
    addr_o  = 8'h00;
    wr_o    = 1'b0;
    wdata_o = 8'h00;
    rd_o    = 1'b0;
    taken_o = 1'b0;
    trig_o  = 1'b0;
  end
  ////////////////////////////////////////
  // legal codes only; standby is not modelled here
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= 1'b1;
    @(posedge clk_i);
    wr_o    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o   <= 1'b1;
    @(posedge clk_i);
    rd_o   <= 1'b0;
    @(posedge clk_i);
    #1 d = rdata_i;
  endtask
  // settle past the clearing edge before returning
  task automatic ack();
    @(posedge clk_i);
    taken_o <= 1'b1;
    @(posedge clk_i);
    taken_o <= 1'b0;
    #1;
  endtask
  task automatic pin(input logic v);
    @(posedge link_clk_i);
    trig_o <= v;
  endtask
endmodule // acf_host_model

// ---- testbench/acf_config_top_bench.sv ----
/*
  self-checking bench for the configuration bank: registers, routing,
  watermark, rates, high-pass and trigger modes.
  assumes rate base 20 and interpolation ceiling 100 cycles.
*/
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin n_errors++; $display("BAD %s exp %0h got %0h", nm, ex, got); end end
module acf_config_top_bench;
  import acf_pkg::*;
  localparam int BASE = 20;
  localparam int IMAX = 100;
  logic               sys_clk, rst, link_clk, trig, wr, rd, taken, ovr, act, pol, rdy, full, irq_a, irq_b;
  logic [7:0]         addr, wdata, rdata;
  logic signed [19:0] adc, smp;
  logic [6:0]         bcnt;
  int                 n_errors = 0;
  int                 compares = 0;

  acf_config_top #(.ODR_BASE(BASE), .INTERP_MAX(IMAX)) u_acf_config_top (
    .SYS_CLK_I(sys_clk), .RST_I(rst), .LINK_CLK_I(link_clk), .SYNC_TRIG_I(trig),
    .REG_ADDR_I(addr), .REG_WR_I(wr), .REG_WDATA_I(wdata), .REG_RD_I(rd), .REG_RDATA_O(rdata),
    .ADC_DATA_I(adc), .SAMPLE_TAKEN_I(taken), .SAMPLE_DATA_O(smp), .DATA_READY_O(rdy),
    .BUF_COUNT_I(bcnt), .BUF_OVERRUN_I(ovr), .ACTIVITY_I(act), .IRQ_POLARITY_I(pol),
    .BUF_FULL_O(full), .IRQ_A_O(irq_a), .IRQ_B_O(irq_b));
  acf_host_model u_acf_host_model (
    .clk_i(sys_clk), .link_clk_i(link_clk), .rdata_i(rdata), .addr_o(addr), .wr_o(wr),
    .wdata_o(wdata), .rd_o(rd), .taken_o(taken), .trig_o(trig));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #24 link_clk = ~link_clk;
  end
  ////////////////////////////////////////
  task automatic complete_run();
    if (n_errors == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic wait_rdy(output int n);
    n = 0;
    while (rdy !== 1'b1 && n < 30000) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
  endtask
  task automatic t_regs();
    logic [7:0] ad [4] = '{ADDR_FILTER, ADDR_WMARK, ADDR_ROUTE, ADDR_TSYNC};
    logic [7:0] rv [4] = '{RST_FILTER, RST_WMARK, RST_ROUTE, RST_TSYNC};
    logic [7:0] mk [4] = '{MASK_FILTER, MASK_WMARK, MASK_ROUTE, MASK_TSYNC};
    logic [7:0] wv [4] = '{8'hea, 8'he0, 8'ha5, 8'hfe};
    logic [7:0] d;
    for (int i = 0; i < 4; i++) begin
      u_acf_host_model.rd(ad[i], d);
      `CHK("reset", rv[i], d)
      u_acf_host_model.wr(ad[i], wv[i]);
      u_acf_host_model.wr(8'h30, 8'hff);
      u_acf_host_model.rd(ad[i], d);
      `CHK("masked", wv[i] & mk[i], d)
      u_acf_host_model.wr(ad[i], rv[i]);
    end
    u_acf_host_model.rd(8'h2c, d);
    `CHK("unmapped", 8'h00, d)
  endtask
  task automatic t_route();
    logic ea, eb;
    for (int p = 0; p < 2; p++)
      for (int b = 1; b < 8; b++)
        for (int e = 1; e < 4; e++) begin
          if (b == 4) continue;
          u_acf_host_model.wr(ADDR_ROUTE, 8'h01 << b);
          @(posedge sys_clk);
          pol  <= p[0];
          ovr  <= (e == EV_OVR);
          act  <= (e == EV_ACT);
          bcnt <= (e == EV_FULL) ? 7'h60 : 7'h00;
          repeat (3) @(posedge sys_clk);
          #1;
          ea = ~((b == e) ^ p[0]);
          eb = ~((b == e + 4) ^ p[0]);
          `CHK("irq_a", ea, irq_a)
          `CHK("irq_b", eb, irq_b)
        end
    @(posedge sys_clk);
    ovr  <= 1'b0;
    act  <= 1'b0;
    bcnt <= 7'h00;
  endtask
  task automatic t_wmark();
    logic [6:0] wm [6] = '{7'd5, 7'd5, 7'd5, 7'd1, 7'd1, 7'd96};
    logic [6:0] ct [6] = '{7'd4, 7'd5, 7'd4, 7'd0, 7'd1, 7'd96};
    for (int i = 0; i < 6; i++) begin
      u_acf_host_model.wr(ADDR_WMARK, {1'b0, wm[i]});
      @(posedge sys_clk);
      bcnt <= ct[i];
      repeat (3) @(posedge sys_clk);
      #1;
      `CHK("full", ct[i] >= wm[i], full)
    end
    u_acf_host_model.wr(ADDR_WMARK, RST_WMARK);
  endtask
  task automatic t_rate();
    int c [3] = '{0, 1, 10};
    int n;
    for (int i = 0; i < 3; i++) begin
      u_acf_host_model.wr(ADDR_FILTER, c[i][7:0]);
      u_acf_host_model.ack();
      wait_rdy(n);
      u_acf_host_model.ack();
      wait_rdy(n);
      `CHK("period", (BASE << c[i]) - 2, n)
      `CHK("bypass", adc, smp)
    end
    u_acf_host_model.wr(ADDR_FILTER, 8'h00);
    u_acf_host_model.wr(ADDR_TSYNC, 8'h04);
    u_acf_host_model.ack();
    wait_rdy(n);
    u_acf_host_model.ack();
    wait_rdy(n);
    `CHK("ext_period", 1'b1, n >= 34 && n <= 39)
    u_acf_host_model.wr(ADDR_TSYNC, 8'h00);
  endtask
  task automatic t_hpf();
    int n;
    u_acf_host_model.wr(ADDR_ROUTE, 8'h11);
    u_acf_host_model.wr(ADDR_FILTER, 8'h10);
    repeat (6) begin
      u_acf_host_model.ack();
      wait_rdy(n);
    end
    `CHK("pin_rdy", 2'b11, {irq_a, irq_b})
    `CHK("hp_decay", 1'b1, smp < adc)
  endtask
  task automatic t_trig();
    logic [7:0] md [3] = '{8'h01, 8'h02, 8'h02};
    logic [7:0] rc [3] = '{8'h0a, 8'h0a, 8'h00};
    int         lo [3] = '{2, IMAX, INTERP_MIN_CYC};
    int         n;
    for (int i = 0; i < 3; i++) begin
      u_acf_host_model.wr(ADDR_FILTER, rc[i]);
      u_acf_host_model.wr(ADDR_TSYNC, md[i]);
      u_acf_host_model.ack();
      u_acf_host_model.pin(1'b1);
      wait_rdy(n);
      `CHK("trig_lat", 1'b1, n >= lo[i] && n <= lo[i] + 12)
      u_acf_host_model.pin(1'b0);
      repeat (4) @(posedge link_clk);
    end
    u_acf_host_model.wr(ADDR_TSYNC, 8'h00);
  endtask
  ////////////////////////////////////////
  initial begin
    rst  = 1'b1;
    adc  = 20'sh01234;
    bcnt = 7'h00;
    ovr  = 1'b0;
    act  = 1'b0;
    pol  = 1'b0;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    t_regs();
    t_route();
    t_wmark();
    t_rate();
    t_hpf();
    t_trig();
    complete_run();
  end
  initial begin
    #8_000_000;
    n_errors++;
    complete_run();
  end
endmodule // acf_config_top_bench
